// [rtl/swr_params.svh]
// constants of the single-wire slave rom layer: timings, command codes, reset values
`ifndef SWR_PARAMS_SVH
`define SWR_PARAMS_SVH

// ==========================================================
// clock and speeds
`define SWR_CLK_PERIOD_NS 5
`define SWR_RATE_STD_BPS 9090
`define SWR_RATE_FAST_BPS 62500
`define SWR_CYC_MIN(t) (((t) + `SWR_CLK_PERIOD_NS - 1) / `SWR_CLK_PERIOD_NS)

// ==========================================================
// slot timing, standard then fast
`define SWR_T_SAMPLE_STD_NS 30000
`define SWR_T_SAMPLE_FAST_NS 3000
`define SWR_T_HOLD0_STD_NS 30000
`define SWR_T_HOLD0_FAST_NS 3000
`define SWR_T_RST_STD_NS 120000
`define SWR_T_RST_FAST_NS 16000
`define SWR_T_RST_LONG_NS 480000
`define SWR_T_PWAIT_STD_NS 30000
`define SWR_T_PWAIT_FAST_NS 3000
`define SWR_T_PRES_STD_NS 120000
`define SWR_T_PRES_FAST_NS 12000
`define SWR_TMR_W 18

// ==========================================================
// selection commands, sizes and reset values
`define SWR_CMD_SEARCH 8'hF0
`define SWR_CMD_READ 8'h33
`define SWR_CMD_MATCH 8'h55
`define SWR_CMD_SKIP 8'hCC
`define SWR_CMD_RESUME 8'hA5
`define SWR_CMD_FAST_SKIP 8'h3C
`define SWR_CMD_FAST_MATCH 8'h69
`define SWR_CMD_BITS 8
`define SWR_ID_BITS 64
`define SWR_RST_FAST 1'b0
`define SWR_RST_RESUME 1'b0

`endif

// [rtl/swr_pkg.sv]
// types of the single-wire slave rom layer
package swr_pkg;

	typedef enum logic [1:0] {
		L_IDLE = 2'b00,
		L_SLOT = 2'b01,
		L_PWAIT = 2'b10,
		L_PDRV = 2'b11
	} swr_link_st_t;

	typedef enum logic [3:0] {
		P_WAIT = 4'b0000,
		P_CMD = 4'b0001,
		P_READ = 4'b0010,
		P_MATCH = 4'b0011,
		P_SRCH_T = 4'b0100,
		P_SRCH_C = 4'b0101,
		P_SRCH_W = 4'b0110,
		P_FUNC = 4'b0111,
		P_DEAD = 4'b1000
	} swr_proto_st_t;

	typedef struct packed {
		logic valid;
		logic data;
	} swr_bit_t;

	typedef struct packed {
		logic rst;
		logic long_rst;
		logic valid;
		logic data;
	} swr_evt_t;

endpackage : swr_pkg

// [rtl/swr_sync.sv]
// two-flop synchroniser for the line input
`timescale 1ns/1ps
`default_nettype none

module swr_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_d,
	output logic o_q
);

	logic meta_r;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_r <= RST_VAL;
			o_q <= RST_VAL;
		end else begin
			meta_r <= i_d;
			o_q <= meta_r;
		end
	end

endmodule : swr_sync

`default_nettype wire

// [rtl/swr_timer.sv]
// saturating cycle counter restarted by a clear pulse
`timescale 1ns/1ps
`default_nettype none

module swr_timer #(
	parameter int W = 18
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_clr,
	output logic [W-1:0] o_cnt
);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_cnt <= '0;
		end else if (i_clr) begin
			o_cnt <= '0;
		end else if (o_cnt != {W{1'b1}}) begin
			o_cnt <= o_cnt + 1'b1;
		end
	end

endmodule : swr_timer

`default_nettype wire

// [rtl/swr_rom_layer.sv]
// slave rom layer of a single-wire open-drain bus: slot timing and selection commands
//
// Overview of operation
// - line is only pulled low via open-drain enable, otherwise released
// - two speeds: standard and fast, each with its own timing set
// - order: reset, one selection command, function command, data
// - reset pulse from master is answered by a device presence pulse
// - master makes every falling edge except the presence pulse
// - fast flag switches all waveform timings to the fast set except the long reset time
// - each slot carries exactly one bit, written or read
// - slot timer starts at the falling edge; sets sample and hold
// - returning zero, device pulls low at once, released by its timer
// - returning one, device never pulls the line low
// - selection commands are one byte of write slots after presence
// - seven selection commands decoded; search is F0
// - 33 returns the identity; 55 selects on matching identity
// - CC selects without addressing
// - A5 selects only when the resume flag is set
// - 3C sets fast speed for all; 69 for the matching device
// - after selection, control passes to the function command layer
// - resume flag set by match, search, fast match; cleared by read, skip, fast skip and failed match or search
// - a reset low for the long time returns to standard speed
// - search: send bit, complement, read choice; drop on mismatch
// - match compares 64 bits; on mismatch waits for next reset
`timescale 1ns/1ps
`default_nettype none
`include "swr_params.svh"

module swr_rom_layer #(
	parameter int unsigned SMP_STD = `SWR_CYC_MIN(`SWR_T_SAMPLE_STD_NS),
	parameter int unsigned SMP_FAST = `SWR_CYC_MIN(`SWR_T_SAMPLE_FAST_NS),
	parameter int unsigned HOLD_STD = `SWR_CYC_MIN(`SWR_T_HOLD0_STD_NS),
	parameter int unsigned HOLD_FAST = `SWR_CYC_MIN(`SWR_T_HOLD0_FAST_NS),
	parameter int unsigned RST_STD = `SWR_CYC_MIN(`SWR_T_RST_STD_NS),
	parameter int unsigned RST_FAST = `SWR_CYC_MIN(`SWR_T_RST_FAST_NS),
	parameter int unsigned RST_LONG = `SWR_CYC_MIN(`SWR_T_RST_LONG_NS),
	parameter int unsigned PWAIT_STD = `SWR_CYC_MIN(`SWR_T_PWAIT_STD_NS),
	parameter int unsigned PWAIT_FAST = `SWR_CYC_MIN(`SWR_T_PWAIT_FAST_NS),
	parameter int unsigned PRES_STD = `SWR_CYC_MIN(`SWR_T_PRES_STD_NS),
	parameter int unsigned PRES_FAST = `SWR_CYC_MIN(`SWR_T_PRES_FAST_NS)
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_line_i,
	output logic o_line_o,
	output logic o_line_oe,
	input wire logic [`SWR_ID_BITS-1:0] i_rom_id,
	input wire logic i_fn_tx_en,
	input wire logic i_fn_tx_bit,
	input wire logic i_fn_release,
	output logic o_fn_active,
	output swr_pkg::swr_bit_t o_fn_rx,
	output logic o_fast_speed,
	output logic o_resume_flag
);

	localparam int CW = `SWR_TMR_W;
	localparam int BW = $clog2(`SWR_ID_BITS);

	// ==========================================================
	// line input and slot timer
	logic line_s;
	logic line_q;
	logic fall;
	logic tmr_clr;
	logic [CW-1:0] cnt;

	swr_sync #(
		.RST_VAL(1'b1)
	) u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_d(i_line_i),
		.o_q(line_s)
	);

	swr_timer #(
		.W(CW)
	) u_timer (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_clr(tmr_clr),
		.o_cnt(cnt)
	);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			line_q <= 1'b1;
		end else begin
			line_q <= line_s;
		end
	end

	assign fall = line_q & ~line_s;

	// ==========================================================
	// timing set chosen by speed
	logic [CW-1:0] smp_c;
	logic [CW-1:0] hold_c;
	logic [CW-1:0] rst_c;
	logic [CW-1:0] pw_c;
	logic [CW-1:0] pres_c;
	logic [CW-1:0] long_c;

	always_comb begin
		smp_c = o_fast_speed ? CW'(SMP_FAST) : CW'(SMP_STD);
		hold_c = o_fast_speed ? CW'(HOLD_FAST) : CW'(HOLD_STD);
		rst_c = o_fast_speed ? CW'(RST_FAST) : CW'(RST_STD);
		pw_c = o_fast_speed ? CW'(PWAIT_FAST) : CW'(PWAIT_STD);
		pres_c = o_fast_speed ? CW'(PRES_FAST) : CW'(PRES_STD);
		long_c = CW'(RST_LONG);
	end

	// ==========================================================
	// link state machine
	swr_pkg::swr_link_st_t lst;
	swr_pkg::swr_proto_st_t pst;
	swr_pkg::swr_evt_t evt;
	logic drive0;
	logic slot_end;

	// slot closes only once sampled, line high and our pulldown off
	assign slot_end = (lst == swr_pkg::L_SLOT) && (cnt >= smp_c) && line_s && !o_line_oe;

	always_comb begin
		evt = '0;
		evt.valid = (lst == swr_pkg::L_SLOT) && (cnt == smp_c - 1'b1);
		evt.data = line_s;
		evt.rst = slot_end && (cnt > rst_c);
		evt.long_rst = slot_end && (cnt >= long_c);
	end

	always_comb begin
		tmr_clr = 1'b0;
		if (lst == swr_pkg::L_IDLE && fall) begin
			tmr_clr = 1'b1;
		end else if (evt.rst) begin
			tmr_clr = 1'b1;
		end else if (lst == swr_pkg::L_PWAIT && cnt == pw_c - 1'b1) begin
			tmr_clr = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lst <= swr_pkg::L_IDLE;
		end else begin
			case (lst)
				swr_pkg::L_IDLE: begin
					if (fall) begin
						lst <= swr_pkg::L_SLOT;
					end
				end
				swr_pkg::L_SLOT: begin
					if (evt.rst) begin
						lst <= swr_pkg::L_PWAIT;
					end else if (slot_end) begin
						lst <= swr_pkg::L_IDLE;
					end
				end
				swr_pkg::L_PWAIT: begin
					if (cnt == pw_c - 1'b1) begin
						lst <= swr_pkg::L_PDRV;
					end
				end
				swr_pkg::L_PDRV: begin
					if (cnt == pres_c - 1'b1) begin
						lst <= swr_pkg::L_IDLE;
					end
				end
				default: begin
					lst <= swr_pkg::L_IDLE;
				end
			endcase
		end
	end

	// open-drain: data pin stays low, only the enable moves
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_line_o <= 1'b0;
			o_line_oe <= 1'b0;
		end else begin
			o_line_o <= 1'b0;
			if (lst == swr_pkg::L_IDLE && fall) begin
				o_line_oe <= drive0;
			end else if (lst == swr_pkg::L_SLOT && cnt == hold_c - 1'b1) begin
				o_line_oe <= 1'b0;
			end else if (lst == swr_pkg::L_PWAIT && cnt == pw_c - 1'b1) begin
				o_line_oe <= 1'b1;
			end else if (lst == swr_pkg::L_PDRV && cnt == pres_c - 1'b1) begin
				o_line_oe <= 1'b0;
			end
		end
	end

	// ==========================================================
	// selection command layer
	logic [`SWR_CMD_BITS-1:0] cmd_sr;
	logic [`SWR_CMD_BITS-1:0] cmd_byte;
	logic [BW-1:0] bcnt;
	logic cmd_done;
	logic id_bit;
	logic last_bit;
	logic mism_r;
	logic fast_prev_r;
	logic fast_match_r;
	logic tx_en;
	logic tx_bit;

	assign cmd_byte = {evt.data, cmd_sr[`SWR_CMD_BITS-1:1]};
	assign cmd_done = evt.valid && pst == swr_pkg::P_CMD && bcnt == BW'(`SWR_CMD_BITS - 1);
	assign id_bit = i_rom_id[bcnt];
	assign last_bit = bcnt == BW'(`SWR_ID_BITS - 1);

	always_comb begin
		tx_en = 1'b0;
		tx_bit = 1'b1;
		case (pst)
			swr_pkg::P_READ, swr_pkg::P_SRCH_T: begin
				tx_en = 1'b1;
				tx_bit = id_bit;
			end
			swr_pkg::P_SRCH_C: begin
				tx_en = 1'b1;
				tx_bit = ~id_bit;
			end
			swr_pkg::P_FUNC: begin
				tx_en = i_fn_tx_en;
				tx_bit = i_fn_tx_bit;
			end
			default: begin
				tx_en = 1'b0;
			end
		endcase
	end

	assign drive0 = tx_en && !tx_bit;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmd_sr <= '0;
		end else if (evt.valid && pst == swr_pkg::P_CMD) begin
			cmd_sr <= cmd_byte;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pst <= swr_pkg::P_WAIT;
			bcnt <= '0;
			mism_r <= 1'b0;
		end else if (evt.rst) begin
			pst <= swr_pkg::P_CMD;
			bcnt <= '0;
			mism_r <= 1'b0;
		end else if (pst == swr_pkg::P_FUNC && i_fn_release) begin
			pst <= swr_pkg::P_DEAD;
		end else if (evt.valid) begin
			case (pst)
				swr_pkg::P_CMD: begin
					bcnt <= bcnt + 1'b1;
					if (cmd_done) begin
						bcnt <= '0;
						case (cmd_byte)
							`SWR_CMD_READ: pst <= swr_pkg::P_READ;
							`SWR_CMD_MATCH: pst <= swr_pkg::P_MATCH;
							`SWR_CMD_FAST_MATCH: pst <= swr_pkg::P_MATCH;
							`SWR_CMD_SEARCH: pst <= swr_pkg::P_SRCH_T;
							`SWR_CMD_SKIP: pst <= swr_pkg::P_FUNC;
							`SWR_CMD_FAST_SKIP: pst <= swr_pkg::P_FUNC;
							`SWR_CMD_RESUME: begin
								pst <= o_resume_flag ? swr_pkg::P_FUNC : swr_pkg::P_DEAD;
							end
							default: pst <= swr_pkg::P_DEAD;
						endcase
					end
				end
				swr_pkg::P_READ: begin
					bcnt <= bcnt + 1'b1;
					if (last_bit) begin
						pst <= swr_pkg::P_FUNC;
					end
				end
				swr_pkg::P_MATCH: begin
					bcnt <= bcnt + 1'b1;
					if (evt.data != id_bit) begin
						mism_r <= 1'b1;
					end
					if (last_bit) begin
						pst <= (mism_r || evt.data != id_bit) ? swr_pkg::P_DEAD : swr_pkg::P_FUNC;
					end
				end
				swr_pkg::P_SRCH_T: pst <= swr_pkg::P_SRCH_C;
				swr_pkg::P_SRCH_C: pst <= swr_pkg::P_SRCH_W;
				swr_pkg::P_SRCH_W: begin
					bcnt <= bcnt + 1'b1;
					if (evt.data != id_bit) begin
						pst <= swr_pkg::P_DEAD;
					end else if (last_bit) begin
						pst <= swr_pkg::P_FUNC;
					end else begin
						pst <= swr_pkg::P_SRCH_T;
					end
				end
				default: pst <= pst;
			endcase
		end
	end

	// ==========================================================
	// speed and resume flags
	logic match_ok;
	logic match_end;

	assign match_end = evt.valid && pst == swr_pkg::P_MATCH && last_bit;
	assign match_ok = !mism_r && evt.data == id_bit;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_fast_speed <= `SWR_RST_FAST;
			fast_prev_r <= `SWR_RST_FAST;
			fast_match_r <= 1'b0;
		end else if (evt.long_rst) begin
			o_fast_speed <= 1'b0;
			fast_match_r <= 1'b0;
		end else if (evt.rst) begin
			fast_match_r <= 1'b0;
		end else if (cmd_done && cmd_byte == `SWR_CMD_FAST_SKIP) begin
			o_fast_speed <= 1'b1;
		end else if (cmd_done && cmd_byte == `SWR_CMD_FAST_MATCH) begin
			fast_prev_r <= o_fast_speed;
			fast_match_r <= 1'b1;
			o_fast_speed <= 1'b1;
		end else if (match_end && fast_match_r && !match_ok) begin
			// a device already fast stays fast after losing the match
			o_fast_speed <= fast_prev_r;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_resume_flag <= `SWR_RST_RESUME;
		end else if (match_end) begin
			o_resume_flag <= match_ok;
		end else if (evt.valid && pst == swr_pkg::P_SRCH_W) begin
			if (evt.data != id_bit) begin
				o_resume_flag <= 1'b0;
			end else if (last_bit) begin
				o_resume_flag <= 1'b1;
			end
		end else if (cmd_done && (cmd_byte == `SWR_CMD_SKIP || cmd_byte == `SWR_CMD_FAST_SKIP
				|| cmd_byte == `SWR_CMD_READ)) begin
			o_resume_flag <= 1'b0;
		end
	end

	// ==========================================================
	// hand-over to the function layer
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_fn_active <= 1'b0;
			o_fn_rx <= '0;
		end else begin
			o_fn_rx.valid <= evt.valid && pst == swr_pkg::P_FUNC && !evt.rst;
			o_fn_rx.data <= evt.data;
			if (evt.rst) begin
				o_fn_active <= 1'b0;
			end else begin
				o_fn_active <= pst == swr_pkg::P_FUNC && !i_fn_release;
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_fall_tx0;
		lst == swr_pkg::L_IDLE && fall && drive0;
	endsequence

	sequence s_cmd(logic [7:0] c);
		cmd_done && cmd_byte == c;
	endsequence

	a_zero_start: assert property (s_fall_tx0 |=> o_line_oe && lst == swr_pkg::L_SLOT)
		else $error("read zero pulldown did not start");
	a_one_no_pull: assert property ((lst == swr_pkg::L_SLOT && !o_line_oe) |=> !o_line_oe)
		else $error("line pulled low inside a slot not returning zero");
	a_hold_bound: assert property ((lst == swr_pkg::L_SLOT && o_line_oe) |-> cnt < hold_c)
		else $error("zero pulldown held past its time");
	a_own_edge: assert property ($rose(o_line_oe) |-> $past(lst) == swr_pkg::L_PWAIT
		|| ($past(lst) == swr_pkg::L_IDLE && !line_s))
		else $error("device made a falling edge outside presence");
	a_pres_len: assert property (lst == swr_pkg::L_PDRV |-> o_line_oe && cnt < pres_c)
		else $error("presence pulse wrong");
	a_one_sample: assert property (evt.valid |-> lst == swr_pkg::L_SLOT
		##1 !evt.valid [*2])
		else $error("more than one bit per slot");
	a_reset_class: assert property (evt.rst |-> cnt > rst_c ##1 lst == swr_pkg::L_PWAIT)
		else $error("reset classified wrongly");
	a_cmd_byte: assert property (cmd_done |=> pst != swr_pkg::P_CMD)
		else $error("command byte not closed after eight bits");
	a_skip_sel: assert property (s_cmd(`SWR_CMD_SKIP) |=> pst == swr_pkg::P_FUNC ##1 o_fn_active)
		else $error("skip did not select");
	a_resume_gate: assert property (s_cmd(`SWR_CMD_RESUME) ##0 !o_resume_flag
		|=> pst == swr_pkg::P_DEAD)
		else $error("resume selected without flag");
	a_fast_skip: assert property (s_cmd(`SWR_CMD_FAST_SKIP) |=> o_fast_speed)
		else $error("fast skip did not set speed");
	a_long_reset: assert property (evt.long_rst |=> !o_fast_speed)
		else $error("long reset kept fast speed");
	a_init_first: assert property (evt.rst |=> pst == swr_pkg::P_CMD ##1 !o_fn_active)
		else $error("reset did not restart the sequence");
	a_search_drop: assert property ((evt.valid && pst == swr_pkg::P_SRCH_W && evt.data != id_bit)
		|=> pst == swr_pkg::P_DEAD && !o_resume_flag)
		else $error("search mismatch not dropped");
	a_match_fail: assert property ((match_end && !match_ok) |=> pst == swr_pkg::P_DEAD)
		else $error("match mismatch not dropped");

endmodule : swr_rom_layer

`default_nettype wire

// [dv/swr_master_model.sv]
// bus master model driving the single-wire line for the rom layer bench
`timescale 1ns/1ps
`default_nettype none

module swr_master_model (
	input wire logic i_clk,
	input wire logic i_line,
	output logic o_pull
);
	// ==========================================
	// speed, set by the bench; slots and presence sampling follow it, the reset low time comes from the caller
	logic fast = 1'b0;
	// extra recovery cycles, as a master on a shared line would add
	int extra_rec = 0;
	initial o_pull = 1'b0;

	// ==========================================
	// one slot; write-one and read share the short low
	task automatic slot(input logic w, output logic r);
		int lo;
		int sm;
		int sl;
		lo = w ? (fast ? 2 : 3) : (fast ? 14 : 30);
		sm = fast ? 7 : 12;
		sl = (fast ? 20 : 40) + extra_rec;
		for (int c = 0; c < sl; c++) begin
			@(posedge i_clk);
			o_pull <= (c < lo);
			@(negedge i_clk);
			if (c == sm) r = i_line;
		end
	endtask : slot

	// ==========================================
	// reset pulse, then look for presence while the line is released
	task automatic bus_reset(input int n, output logic p);
		int sm;
		int tot;
		sm = fast ? 14 : 25;
		tot = fast ? 30 : 70;
		@(posedge i_clk);
		o_pull <= 1'b1;
		repeat (n) @(posedge i_clk);
		o_pull <= 1'b0;
		for (int c = 0; c < tot; c++) begin
			@(negedge i_clk);
			if (c == sm) p = i_line;
			@(posedge i_clk);
		end
	endtask : bus_reset
endmodule : swr_master_model
`default_nettype wire

// [dv/testbench.sv]
// self-checking bench of the single-wire slave rom layer
`timescale 1ns/1ps
`default_nettype none
`include "swr_params.svh"

module testbench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [63:0] id = 64'h0;
	logic tx_en = 1'b0;
	logic tx_bit = 1'b0;
	logic fn_rel = 1'b0;
	logic pull;
	logic oe;
	logic lo;
	logic act;
	logic res;
	logic fast;
	swr_pkg::swr_bit_t rx;
	wire logic line;
	logic [31:0] seed = 32'h0000001C;
	int error_cnt = 0;
	int n_tests = 0;
	int rx_cnt = 0;
	logic rx_last = 1'b0;
	int cyc = 0;

	// pull-up: high unless some party pulls
	assign line = !(pull || (oe && !lo));

	swr_master_model master (.i_clk(clk), .i_line(line), .o_pull(pull));

	// short counts keep the run small; zero hold equals the sample point, as in the defaults
	localparam int unsigned T_SMP_STD = 20;
	localparam int unsigned T_SMP_FAST = 8;
	localparam int unsigned T_RST_STD = 100;
	localparam int unsigned T_RST_FAST = 40;
	localparam int unsigned T_RST_LONG = 300;
	localparam int unsigned T_PWAIT_STD = 10;
	localparam int unsigned T_PWAIT_FAST = 4;
	localparam int unsigned T_PRES_STD = 40;
	localparam int unsigned T_PRES_FAST = 16;

	swr_rom_layer #(.SMP_STD(T_SMP_STD), .SMP_FAST(T_SMP_FAST), .HOLD_STD(T_SMP_STD),
		.HOLD_FAST(T_SMP_FAST), .RST_STD(T_RST_STD), .RST_FAST(T_RST_FAST),
		.RST_LONG(T_RST_LONG), .PWAIT_STD(T_PWAIT_STD), .PWAIT_FAST(T_PWAIT_FAST),
		.PRES_STD(T_PRES_STD), .PRES_FAST(T_PRES_FAST)) dut (
		.i_clk(clk), .i_rst_n(rst_n), .i_line_i(line), .o_line_o(lo),
		.o_line_oe(oe), .i_rom_id(id), .i_fn_tx_en(tx_en), .i_fn_tx_bit(tx_bit),
		.i_fn_release(fn_rel), .o_fn_active(act), .o_fn_rx(rx),
		.o_fast_speed(fast), .o_resume_flag(res));

	initial begin
		forever #2.5 clk = ~clk;
	end

	// ==========================================
	// helpers
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	task automatic chk_bit(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_bit

	task automatic chk_vec(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_vec

	task automatic st(input logic [2:0] e);
		chk_vec("active resume fast", {61'h0, e}, {61'h0, act, res, fast});
	endtask : st

	task automatic done(input string nm);
		$display("test %s done", nm);
	endtask : done

	task automatic init(input int n);
		logic p;
		master.bus_reset(n, p);
		chk_bit("presence", 1'b0, p);
	endtask : init

	task automatic wr_byte(input logic [7:0] b);
		logic r;
		for (int i = 0; i < 8; i++) master.slot(b[i], r);
	endtask : wr_byte

	task automatic wr_id(input logic [63:0] b);
		logic r;
		for (int i = 0; i < 64; i++) master.slot(b[i], r);
	endtask : wr_id

	task automatic rel();
		@(posedge clk);
		fn_rel <= 1'b1;
		repeat (2) @(posedge clk);
		fn_rel <= 1'b0;
	endtask : rel

	// random read and write slots handed over to the function layer
	task automatic fn_xfer();
		logic [31:0] v;
		logic r;
		int c0;
		for (int i = 0; i < 4; i++) begin
			v = rnd();
			@(posedge clk);
			tx_en <= 1'b1;
			tx_bit <= v[0];
			master.slot(1'b1, r);
			chk_bit("fn read bit", v[0], r);
			@(posedge clk);
			tx_en <= 1'b0;
			c0 = rx_cnt;
			master.slot(v[1], r);
			chk_vec("fn rx count", 64'(c0 + 1), 64'(rx_cnt));
			chk_bit("fn rx data", v[1], rx_last);
		end
	endtask : fn_xfer

	task automatic srch(input logic [63:0] ch);
		logic t;
		logic c;
		logic alive;
		alive = 1'b1;
		init(150);
		wr_byte(`SWR_CMD_SEARCH);
		for (int i = 0; i < 64; i++) begin
			master.slot(1'b1, t);
			master.slot(1'b1, c);
			chk_vec("search pair", alive ? {62'h0, id[i], !id[i]} : 64'h3, {62'h0, t, c});
			master.slot(ch[i], t);
			if (ch[i] !== id[i]) alive = 1'b0;
		end
		st({alive, alive, 1'b0});
	endtask : srch

	always @(posedge clk) begin
		if (rx.valid === 1'b1) begin
			rx_cnt <= rx_cnt + 1;
			rx_last <= rx.data;
		end
	end

	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			error_cnt++;
			wrap_up();
		end
	end

	// ==========================================
	// main sequence
	initial begin
		logic r;
		logic [63:0] v;
		int k;
		repeat (2) @(posedge clk);
		v[31:0] = rnd();
		v[63:32] = rnd();
		id <= v;
		master.extra_rec = int'(rnd() % 4);
		repeat (9) @(posedge clk);
		@(negedge clk);
		chk_vec("reset outputs", 64'h0, {57'h0, oe, lo, act, res, fast, rx});
		@(posedge clk);
		rst_n <= 1'b1;
		master.slot(1'b1, r);
		chk_bit("slot before bus reset", 1'b1, r);
		done("reset");
		init(150);
		wr_byte(`SWR_CMD_READ);
		for (int i = 0; i < 64; i++) begin
			master.slot(1'b1, r);
			v[i] = r;
		end
		chk_vec("read identity", id, v);
		st(3'b100);
		rel();
		done("read");
		init(150);
		wr_byte(`SWR_CMD_SKIP);
		st(3'b100);
		fn_xfer();
		rel();
		st(3'b000);
		done("skip");
		init(150);
		wr_byte(`SWR_CMD_MATCH);
		wr_id(id);
		st(3'b110);
		rel();
		init(150);
		wr_byte(`SWR_CMD_RESUME);
		st(3'b110);
		rel();
		k = rnd() % 64;
		init(150);
		wr_byte(`SWR_CMD_MATCH);
		wr_id(id ^ (64'h1 << k));
		st(3'b000);
		init(150);
		wr_byte(`SWR_CMD_RESUME);
		st(3'b000);
		done("match");
		srch(id);
		rel();
		srch(id ^ (64'h1 << (rnd() % 64)));
		done("search");
		init(150);
		wr_byte(`SWR_CMD_FAST_SKIP);
		st(3'b101);
		rel();
		master.fast = 1'b1;
		init(60);
		wr_byte(`SWR_CMD_SKIP);
		st(3'b101);
		fn_xfer();
		rel();
		init(150);
		st(3'b001);
		master.fast = 1'b0;
		init(350);
		st(3'b000);
		init(150);
		wr_byte(`SWR_CMD_FAST_MATCH);
		master.fast = 1'b1;
		wr_id(id);
		st(3'b111);
		rel();
		master.fast = 1'b0;
		init(350);
		wr_byte(`SWR_CMD_FAST_MATCH);
		master.fast = 1'b1;
		wr_id(id ^ {1'b1, 63'h0});
		chk_bit("speed after failed match", 1'b0, fast);
		master.fast = 1'b0;
		done("fast");
		init(350);
		wr_byte(8'h5A);
		master.slot(1'b1, r);
		chk_bit("unknown command silent", 1'b1, r);
		chk_bit("unknown command idle", 1'b0, act);
		done("unknown");
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
